// >>> logic/banked_mode_register_file.sv
// Mode-banked register file, status words, transfer decode and map.
// Assumes pipeline inputs come from logic on clock_i; bus is Avalon-MM.
`timescale 1ns/1ns
module banked_mode_register_file
  import banked_regs_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            sys_rst_i,
  // Avalon-MM slave
  input  wire logic [4:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  output logic [31:0]          avs_readdata_o,
  output logic                 avs_waitrequest_o,
  // Register port of the pipeline
  input  wire logic [3:0]      rd_sel_i,
  output logic [XLEN-1:0]      rd_data_o,
  input  wire logic            wr_en_i,
  input  wire logic [3:0]      wr_sel_i,
  input  wire logic [XLEN-1:0] wr_data_i,
  input  wire logic            bl_i,
  input  wire logic [XLEN-1:0] bl_ret_addr_i,
  // Status and mode control
  input  wire logic            mode_wr_i,
  input  wire logic [4:0]      mode_wr_val_i,
  input  wire logic            stat_wr_i,
  input  wire logic [XLEN-1:0] stat_wr_data_i,
  input  wire logic            saved_wr_i,
  input  wire logic [XLEN-1:0] saved_wr_data_i,
  input  wire logic            exc_i,
  input  wire logic [4:0]      exc_mode_i,
  input  wire logic [XLEN-1:0] exc_link_i,
  output logic [XLEN-1:0]      pc_o,
  output logic [XLEN-1:0]      cur_status_o,
  output logic [XLEN-1:0]      saved_status_o,
  output logic [4:0]           mode_o,
  output logic                 priv_o,
  // Transfer decode
  input  wire logic [XLEN-1:0] insn_i,
  output logic                 xfer_o,
  output logic                 undef_trap_o,
  output logic                 cfg_rd_o,
  output logic                 cfg_wr_o,
  output logic [3:0]           cfg_sel_o,
  output logic [2:0]           cfg_opc2_o,
  output logic [3:0]           cfg_operand_o,
  output logic [3:0]           cpu_reg_o,
  output logic [3:0]           cond_o,
  // Address map
  input  wire logic [31:0]     mem_addr_i,
  output region_type           region_o
);
  typedef struct packed {
    logic [NUM_GPR-1:0][XLEN-1:0]   gpr;
    logic [NUM_SAVED-1:0][XLEN-1:0] saved;
    logic [XLEN-1:0]                current_status_reg;
    logic [XLEN-1:0]                pc;
    logic [XLEN-1:0]                rd_data;
    logic [31:0]                    bus_rdata;
    logic [3:0]                     bus_sel;
    logic                           bus_ack;
    logic                           xfer;
    logic                           trap;
    logic                           cfg_rd;
    logic                           cfg_wr;
    logic [3:0]                     cfg_sel;
    logic [2:0]                     opc2;
    logic [3:0]                     operand;
    logic [3:0]                     cpu_reg;
    logic [3:0]                     cond;
    region_type                     region;
  } state_type;

  state_type  state_r;
  state_type  state_nxt;
  mode_type   cur_mode;
  logic [2:0] cur_sidx;
  logic [2:0] exc_sidx;
  logic       bus_req;
  logic       bus_wr_now;
  logic       bus_mode_wr;
  logic       exc_ok;
  logic [31:0] stat_val;
  logic       dec_xfer;
  logic       dec_trap;
  logic       dec_rd;
  logic       dec_wr;
  logic [3:0] dec_sel;
  logic [2:0] dec_opc2;
  logic [3:0] dec_oper;
  logic [3:0] dec_reg;
  logic [3:0] dec_cond;
  region_type dec_region;

  copro_decode u_decode (
    .insn_i    (insn_i),
    .mode_i    (state_r.current_status_reg[MODE_HI:MODE_LO]),
    .xfer_o    (dec_xfer),
    .trap_o    (dec_trap),
    .rd_o      (dec_rd),
    .wr_o      (dec_wr),
    .cfg_sel_o (dec_sel),
    .opc2_o    (dec_opc2),
    .operand_o (dec_oper),
    .cpu_reg_o (dec_reg),
    .cond_o    (dec_cond)
  );

  region_decode u_region (
    .addr_i   (mem_addr_i),
    .region_o (dec_region)
  );

  // mode field of the current status
  assign cur_mode = mode_type'(state_r.current_status_reg[MODE_HI:MODE_LO]);
  assign cur_sidx = saved_idx(state_r.current_status_reg[MODE_HI:MODE_LO]);
  assign exc_sidx = saved_idx(exc_mode_i);
  // task and unprivileged modes are never exception targets
  assign exc_ok = exc_i && exc_sidx != SAVED_NONE;

  // Two-cycle bus access: wait first, complete at the second edge
  assign bus_req     = avs_read_i || avs_write_i;
  assign bus_wr_now  = avs_write_i && state_r.bus_ack;
  assign bus_mode_wr = bus_wr_now && avs_address_i == OFS_MODE
                    && valid_mode(avs_writedata_i[MODE_HI:MODE_LO]);
  assign avs_waitrequest_o = bus_req && !state_r.bus_ack;
  assign avs_readdata_o    = state_r.bus_rdata;

  function automatic logic [XLEN-1:0] vis_read(input state_type st,
                                              input mode_type m,
                                              input logic [3:0] r);
    if (r == PC_IDX)
      return st.pc & PC_MASK;
    return st.gpr[phys_gpr(m, r)];
  endfunction : vis_read

  always_comb
  begin
    state_nxt = state_r;
    stat_val  = stat_wr_data_i & STAT_WR_MASK;
    state_nxt.bus_ack = bus_req && !state_r.bus_ack;
    state_nxt.rd_data = vis_read(state_r, cur_mode, rd_sel_i);
    if (bus_req && !state_r.bus_ack && avs_read_i)
    begin
      case (avs_address_i)
        OFS_MODE:  state_nxt.bus_rdata =
                     {27'h0, state_r.current_status_reg[MODE_HI:MODE_LO]};
        OFS_STAT:  state_nxt.bus_rdata = state_r.current_status_reg;
        OFS_SAVED: state_nxt.bus_rdata = saved_status_o;
        OFS_SEL:   state_nxt.bus_rdata = {28'h0, state_r.bus_sel};
        OFS_DATA:  state_nxt.bus_rdata =
                     vis_read(state_r, cur_mode, state_r.bus_sel);
        default:   state_nxt.bus_rdata = 32'h0;
      endcase
    end
    if (bus_wr_now)
    begin
      case (avs_address_i)
        OFS_SEL:   state_nxt.bus_sel = avs_writedata_i[3:0];
        OFS_DATA:
        begin
          if (state_r.bus_sel == PC_IDX)
            state_nxt.pc = avs_writedata_i & PC_MASK;
          else
            state_nxt.gpr[phys_gpr(cur_mode, state_r.bus_sel)] =
              avs_writedata_i;
        end
        default:   state_nxt.bus_sel = state_nxt.bus_sel;
      endcase
    end
    // only the current mode's copy is written
    if (wr_en_i)
    begin
      if (wr_sel_i == PC_IDX)
        state_nxt.pc = wr_data_i & PC_MASK;
      else
        state_nxt.gpr[phys_gpr(cur_mode, wr_sel_i)] = wr_data_i;
    end
    if (bl_i)
      state_nxt.gpr[phys_gpr(cur_mode, LINK_IDX)] = bl_ret_addr_i;
    if (stat_wr_i)
    begin
      // control bits change only when privileged
      if (cur_mode != MODE_UNPRIV)
      begin
        if (!valid_mode(stat_val[MODE_HI:MODE_LO]))
          stat_val[MODE_HI:MODE_LO] = state_r.current_status_reg[MODE_HI:MODE_LO];
        state_nxt.current_status_reg = stat_val;
      end
      else
        state_nxt.current_status_reg[FLAG_HI:FLAG_LO] = stat_val[FLAG_HI:FLAG_LO];
    end
    // writes ignored without a saved bank
    if (saved_wr_i && cur_sidx != SAVED_NONE)
      state_nxt.saved[cur_sidx] = saved_wr_data_i & STAT_WR_MASK;
    if (mode_wr_i && cur_mode != MODE_UNPRIV && valid_mode(mode_wr_val_i))
      state_nxt.current_status_reg[MODE_HI:MODE_LO] = mode_wr_val_i;
    if (bus_mode_wr)
      state_nxt.current_status_reg[MODE_HI:MODE_LO] = avs_writedata_i[MODE_HI:MODE_LO];
    // exception entry saves status in the target bank
    if (exc_ok)
    begin
      state_nxt.saved[exc_sidx] = state_nxt.current_status_reg;
      state_nxt.current_status_reg[MODE_HI:MODE_LO] = exc_mode_i;
      state_nxt.gpr[phys_gpr(mode_type'(exc_mode_i), LINK_IDX)] =
        exc_link_i;
    end
    state_nxt.xfer    = dec_xfer;
    state_nxt.trap    = dec_trap;
    state_nxt.cfg_rd  = dec_rd;
    state_nxt.cfg_wr  = dec_wr;
    state_nxt.cfg_sel = dec_sel;
    state_nxt.opc2    = dec_opc2;
    state_nxt.operand = dec_oper;
    state_nxt.cpu_reg = dec_reg;
    state_nxt.cond    = dec_cond;
    state_nxt.region  = dec_region;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_r        <= '0;
      state_r.current_status_reg   <= CURRENT_STATUS_REG_RESET;
      state_r.pc     <= PC_RESET;
      state_r.region <= REGION_INSN;
    end
    else
      state_r <= state_nxt;
  end

  assign rd_data_o      = state_r.rd_data;
  assign pc_o           = state_r.pc;
  assign cur_status_o   = state_r.current_status_reg;
  // no saved bank reads as zero
  assign saved_status_o = cur_sidx == SAVED_NONE ? 32'h0
                        : state_r.saved[cur_sidx];
  assign mode_o         = state_r.current_status_reg[MODE_HI:MODE_LO];
  assign priv_o         = cur_mode != MODE_UNPRIV;
  assign xfer_o         = state_r.xfer;
  assign undef_trap_o   = state_r.trap;
  assign cfg_rd_o       = state_r.cfg_rd;
  assign cfg_wr_o       = state_r.cfg_wr;
  assign cfg_sel_o      = state_r.cfg_sel;
  assign cfg_opc2_o     = state_r.opc2;
  assign cfg_operand_o  = state_r.operand;
  assign cpu_reg_o      = state_r.cpu_reg;
  assign cond_o         = state_r.cond;
  assign region_o       = state_r.region;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  mode_legal_a: assert property (
    valid_mode(mode_o))
    else $error("mode field holds an illegal code");

  mode_cause_a: assert property (
    $changed(mode_o) |->
      $past(exc_i || mode_wr_i || stat_wr_i || bus_wr_now))
    else $error("mode changed without a cause");

  // task mode never entered by exception
  task_entry_a: assert property (
    (exc_i && exc_mode_i == MODE_PRIV_TASK && !mode_wr_i
      && !stat_wr_i && !bus_wr_now) |=> $stable(mode_o))
    else $error("exception entered task mode");

  user_trap_a: assert property (
    (dec_xfer && cur_mode == MODE_UNPRIV) |=>
      undef_trap_o && !cfg_rd_o && !cfg_wr_o)
    else $error("unprivileged transfer not trapped");

  xfer_dir_a: assert property (
    (dec_xfer && priv_o && insn_i[OPC1_HI:OPC1_LO] == OPC1_ZERO) |=>
      cfg_rd_o == !$past(insn_i[DIR_BIT])
      && cfg_wr_o == $past(insn_i[DIR_BIT]))
    else $error("transfer direction wrong");

  opc1_block_a: assert property (
    (insn_i[OPC1_HI:OPC1_LO] != OPC1_ZERO) |=> !cfg_rd_o && !cfg_wr_o)
    else $error("nonzero primary opcode acted");

  insn_region_a: assert property (
    (mem_addr_i <= INSN_TOP) |=> region_o == REGION_INSN)
    else $error("instruction region decode wrong");

  pc_write_a: assert property (
    (wr_en_i && wr_sel_i == PC_IDX) |=>
      pc_o == ($past(wr_data_i) & PC_MASK))
    else $error("counter write not aligned");

  link_load_a: assert property (
    (bl_i && !exc_i && !mode_wr_i && !stat_wr_i && !bus_wr_now)
      ##1 (rd_sel_i == LINK_IDX && !wr_en_i && !bl_i)
      |=> rd_data_o == $past(bl_ret_addr_i, 2))
    else $error("link register not loaded");

  saved_none_a: assert property (
    (cur_mode inside {MODE_UNPRIV, MODE_PRIV_TASK}) |->
      saved_status_o == 32'h0)
    else $error("saved status visible without bank");

  bus_wait_a: assert property (
    (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule : banked_mode_register_file

// >>> logic/copro_decode.sv
// Field decode of control-coprocessor transfer instructions.
// Assumes the instruction word and current mode are stable in the cycle.
`timescale 1ns/1ns
module copro_decode
  import banked_regs_pkg::*;
(
  input  wire logic [XLEN-1:0] insn_i,
  input  wire logic [4:0]      mode_i,
  output logic                 xfer_o,
  output logic                 trap_o,
  output logic                 rd_o,
  output logic                 wr_o,
  output logic [3:0]           cfg_sel_o,
  output logic [2:0]           opc2_o,
  output logic [3:0]           operand_o,
  output logic [3:0]           cpu_reg_o,
  output logic [3:0]           cond_o
);
  logic opc1_ok;

  assign xfer_o = insn_i[CLASS_HI:CLASS_LO] == COPROC_CLASS
               && insn_i[CPNUM_HI:CPNUM_LO] == SYSCTL_NUM
               && insn_i[MARK_BIT];
  assign opc1_ok = insn_i[OPC1_HI:OPC1_LO] == OPC1_ZERO;
  assign trap_o = xfer_o && mode_i == MODE_UNPRIV;
  assign rd_o = xfer_o && !trap_o && opc1_ok && !insn_i[DIR_BIT];
  assign wr_o = xfer_o && !trap_o && opc1_ok && insn_i[DIR_BIT];
  assign cfg_sel_o = insn_i[CFG_HI:CFG_LO];
  assign opc2_o    = insn_i[OPC2_HI:OPC2_LO];
  assign operand_o = insn_i[OPER_HI:OPER_LO];
  assign cpu_reg_o = insn_i[CPUR_HI:CPUR_LO];
  assign cond_o    = insn_i[COND_HI:COND_LO];
endmodule : copro_decode

// >>> logic/region_decode.sv
// Fixed address-region map of local memories and bus space.
// Assumes a full 32-bit byte address.
`timescale 1ns/1ns
module region_decode
  import banked_regs_pkg::*;
(
  input  wire logic [31:0] addr_i,
  output region_type       region_o
);
  always_comb
  begin
    if (addr_i <= INSN_TOP)
      region_o = REGION_INSN;
    else if (addr_i <= DATA_TOP)
      region_o = REGION_DATA;
    else if (addr_i <= BUF_LO_TOP)
      region_o = REGION_BUF;
    else if (addr_i <= UNBUF_LO_TOP)
      region_o = REGION_UNBUF;
    else if (addr_i <= BUF_HI_TOP)
      region_o = REGION_BUF;
    else if (addr_i >= UNBUF_HI_BASE)
      region_o = REGION_UNBUF;
    else
      region_o = REGION_NONE;
  end
endmodule : region_decode

// >>> pkg/banked_regs_pkg.sv
// Shared types, field positions and helpers for the banked register file.
// Assumes a single core clock and callers on that same clock.
package banked_regs_pkg;
  localparam int XLEN      = 32;
  localparam int NUM_GPR   = 30;
  localparam int NUM_SAVED = 5;

  typedef enum logic [4:0]
  {
    MODE_UNPRIV     = 5'h10,
    MODE_FAST_IRQ   = 5'h11,
    MODE_NORM_IRQ   = 5'h12,
    MODE_SUPERVISOR = 5'h13,
    MODE_MEM_FAULT  = 5'h17,
    MODE_UNKNOWN_OP = 5'h1b,
    MODE_PRIV_TASK  = 5'h1f
  } mode_type;

  typedef enum logic [2:0]
  {
    REGION_INSN    = 3'h0,
    REGION_DATA    = 3'h1,
    REGION_BUF     = 3'h2,
    REGION_UNBUF   = 3'h3,
    REGION_NONE    = 3'h4
  } region_type;

  // Transfer instruction fields
  localparam int         COND_HI = 31, COND_LO = 28;
  localparam int         CLASS_HI = 27, CLASS_LO = 24;
  localparam int         OPC1_HI = 23, OPC1_LO = 21;
  localparam int         DIR_BIT = 20;
  localparam int         CFG_HI = 19, CFG_LO = 16;
  localparam int         CPUR_HI = 15, CPUR_LO = 12;
  localparam int         CPNUM_HI = 11, CPNUM_LO = 8;
  localparam int         OPC2_HI = 7, OPC2_LO = 5;
  localparam int         MARK_BIT = 4;
  localparam int         OPER_HI = 3, OPER_LO = 0;
  localparam logic [3:0] COPROC_CLASS = 4'he;
  localparam logic [3:0] SYSCTL_NUM   = 4'hf;
  localparam logic [2:0] OPC1_ZERO    = 3'h0;

  // Address map bounds
  localparam logic [31:0] INSN_TOP      = 32'h03ff_ffff;
  localparam logic [31:0] DATA_TOP      = 32'h07ff_ffff;
  localparam logic [31:0] BUF_LO_TOP    = 32'h0fff_ffff;
  localparam logic [31:0] UNBUF_LO_TOP  = 32'h1fff_ffff;
  localparam logic [31:0] BUF_HI_TOP    = 32'h2fff_ffff;
  localparam logic [31:0] UNBUF_HI_BASE = 32'hf000_0000;

  // Status word layout
  localparam int          MODE_HI = 4, MODE_LO = 0;
  localparam int          FLAG_HI = 31, FLAG_LO = 27;
  localparam logic [31:0] STAT_WR_MASK = 32'hf800_00ff;
  localparam logic [31:0] CURRENT_STATUS_REG_RESET   = 32'h0000_00d3;
  localparam logic [31:0] PC_RESET     = 32'h0000_0000;
  localparam logic [31:0] PC_MASK      = 32'hffff_fffc;

  // Register indices and physical bank bases
  localparam logic [3:0] FIQ_FIRST = 4'h8;
  localparam logic [3:0] SP_IDX    = 4'hd;
  localparam logic [3:0] LINK_IDX  = 4'he;
  localparam logic [3:0] PC_IDX    = 4'hf;
  localparam logic [4:0] BASE_FIQ  = 5'h0f;
  localparam logic [4:0] BASE_IRQ  = 5'h16;
  localparam logic [4:0] BASE_SVC  = 5'h18;
  localparam logic [4:0] BASE_ABT  = 5'h1a;
  localparam logic [4:0] BASE_UND  = 5'h1c;
  localparam logic [2:0] SAVED_NONE = 3'h7;

  // Bus byte offsets
  localparam logic [4:0] OFS_MODE  = 5'h00;
  localparam logic [4:0] OFS_STAT  = 5'h04;
  localparam logic [4:0] OFS_SAVED = 5'h08;
  localparam logic [4:0] OFS_SEL   = 5'h0c;
  localparam logic [4:0] OFS_DATA  = 5'h10;

  function automatic logic valid_mode(input logic [4:0] m);
    return m inside {MODE_UNPRIV, MODE_FAST_IRQ, MODE_NORM_IRQ,
      MODE_SUPERVISOR, MODE_MEM_FAULT, MODE_UNKNOWN_OP, MODE_PRIV_TASK};
  endfunction : valid_mode

  function automatic logic [4:0] phys_gpr(input mode_type m,
                                         input logic [3:0] r);
    logic [4:0] p;
    p = {1'b0, r};
    case (m)
      MODE_FAST_IRQ:   if (r >= FIQ_FIRST) p = BASE_FIQ + 5'(r - FIQ_FIRST);
      MODE_NORM_IRQ:   if (r >= SP_IDX) p = BASE_IRQ + 5'(r - SP_IDX);
      MODE_SUPERVISOR: if (r >= SP_IDX) p = BASE_SVC + 5'(r - SP_IDX);
      MODE_MEM_FAULT:  if (r >= SP_IDX) p = BASE_ABT + 5'(r - SP_IDX);
      MODE_UNKNOWN_OP: if (r >= SP_IDX) p = BASE_UND + 5'(r - SP_IDX);
      default:         p = {1'b0, r};
    endcase
    return p;
  endfunction : phys_gpr

  function automatic logic [2:0] saved_idx(input logic [4:0] m);
    case (m)
      MODE_FAST_IRQ:   return 3'h0;
      MODE_NORM_IRQ:   return 3'h1;
      MODE_SUPERVISOR: return 3'h2;
      MODE_MEM_FAULT:  return 3'h3;
      MODE_UNKNOWN_OP: return 3'h4;
      default:         return SAVED_NONE;
    endcase
  endfunction : saved_idx
endpackage : banked_regs_pkg

// >>> testbench/pipe_model.sv
// Model of the execute pipeline that drives the register port.
// Assumes one bench process calls its tasks, all on clock_i.
`timescale 1ns/1ns
module pipe_model
(
  input  wire logic        clock_i,
  input  wire logic [31:0] rd_data_i,
  output logic [5:0]       stb_o,
  output logic [4:0]       sel_o,
  output logic [31:0]      d_o,
  output logic [3:0]       rd_sel_o
);
  initial
  begin
    stb_o = '0;
    sel_o = '0;
    d_o = '0;
    rd_sel_o = '0;
  end
  // Strobe k: 0 write, 1 link, 2 status, 3 saved, 4 mode, 5 exception
  task automatic issue(input int k, input logic [4:0] s,
                       input logic [31:0] d);
    @(posedge clock_i);
    stb_o <= 6'(6'h01 << k);
    sel_o <= s;
    d_o   <= d;
    @(posedge clock_i);
    stb_o <= '0;
    // Released data never keeps its last value
    d_o   <= ~d;
    #1;
  endtask : issue
  task automatic rd(input logic [3:0] s, output logic [31:0] q);
    @(posedge clock_i);
    rd_sel_o <= s;
    @(posedge clock_i);
    #1;
    q = rd_data_i;
  endtask : rd
endmodule : pipe_model

// >>> testbench/tb_top.sv
// Bench for the banked register file: bus, pipeline, decode and map.
// Assumes pipe_model drives the register port from its tasks.
`timescale 1ns/1ns
module tb_top
  import banked_regs_pkg::*;
();
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [4:0]  adr = '0;
  logic        rd_q = 1'b0, wr_q = 1'b0, wreq, priv, xf, tr, crd, cwr;
  logic [31:0] wd = '0, rdat, d, rdd, pc, cs, ss, q;
  logic [31:0] insn = '0, maddr = '0;
  logic [5:0]  stb;
  logic [4:0]  sel, md;
  logic [3:0]  rs, cfg, opr, cpr, cnd;
  logic [2:0]  op2;
  region_type  rg;
  int          fails = 0, cmp_count = 0;
  logic [31:0] ad [13] = '{32'h0, 32'h03ff_ffff, 32'h0400_0000,
    32'h07ff_ffff, 32'h0800_0000, 32'h0fff_ffff, 32'h1000_0000,
    32'h1fff_ffff, 32'h2000_0000, 32'h2fff_ffff, 32'h3000_0000,
    32'hf000_0000, 32'hffff_ffff};
  region_type  er [13] = '{REGION_INSN, REGION_INSN, REGION_DATA,
    REGION_DATA, REGION_BUF, REGION_BUF, REGION_UNBUF, REGION_UNBUF,
    REGION_BUF, REGION_BUF, REGION_NONE, REGION_UNBUF, REGION_UNBUF};

  always #10 clock_i = ~clock_i;

  pipe_model pipe_model_i (.clock_i(clock_i), .rd_data_i(rdd), .stb_o(stb),
    .sel_o(sel), .d_o(d), .rd_sel_o(rs));

  banked_mode_register_file banked_mode_register_file_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rd_sel_i(rs),
    .rd_data_o(rdd), .wr_en_i(stb[0]), .wr_sel_i(sel[3:0]),
    .wr_data_i(d), .bl_i(stb[1]), .bl_ret_addr_i(d),
    .mode_wr_i(stb[4]), .mode_wr_val_i(sel), .stat_wr_i(stb[2]),
    .stat_wr_data_i(d), .saved_wr_i(stb[3]), .saved_wr_data_i(d),
    .exc_i(stb[5]), .exc_mode_i(sel), .exc_link_i(d), .pc_o(pc),
    .cur_status_o(cs), .saved_status_o(ss), .mode_o(md), .priv_o(priv),
    .insn_i(insn), .xfer_o(xf), .undef_trap_o(tr), .cfg_rd_o(crd),
    .cfg_wr_o(cwr), .cfg_sel_o(cfg), .cfg_opc2_o(op2),
    .cfg_operand_o(opr), .cpu_reg_o(cpr), .cond_o(cnd),
    .mem_addr_i(maddr), .region_o(rg));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clock_i);
    adr  <= a;
    wd   <= v;
    wr_q <= w;
    rd_q <= ~w;
    do
      @(posedge clock_i);
    while (wreq !== 1'b0 && ++n < 50);
    if (n >= 50)
    begin
      fails++;
      end_of_test();
    end
    q = rdat;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    #1;
  endtask : bus

  task automatic dec(input logic [31:0] i);
    @(posedge clock_i);
    insn <= i;
    @(posedge clock_i);
    #1;
    q = {9'h0, xf, tr, crd, cwr, cfg, op2, opr, cpr, cnd};
  endtask : dec

  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, OFS_MODE, '0);
    chk(q, 32'(MODE_SUPERVISOR));
    pipe_model_i.issue(0, 5'(SP_IDX), 32'h0000_a5a0);
    pipe_model_i.issue(1, '0, 32'h0000_0104);
    pipe_model_i.issue(2, '0, 32'h2000_00d3);
    chk(cs, 32'h2000_00d3);
    bus(1'b1, OFS_MODE, 32'(MODE_PRIV_TASK));
    pipe_model_i.issue(0, 5'(SP_IDX), 32'h0000_5a50);
    pipe_model_i.issue(0, 5'h08, 32'h0000_0808);
    bus(1'b1, OFS_MODE, 32'(MODE_FAST_IRQ));
    pipe_model_i.issue(0, 5'h08, 32'hf1f1_0008);
    bus(1'b1, OFS_MODE, 32'(MODE_UNPRIV));
    chk({31'h0, priv}, '0);
    pipe_model_i.rd(SP_IDX, q);
    chk(q, 32'h0000_5a50);
    pipe_model_i.rd(4'h8, q);
    chk(q, 32'h0000_0808);
    pipe_model_i.issue(4, MODE_SUPERVISOR, '0);
    bus(1'b1, OFS_MODE, 32'h0000_0015);
    chk(32'(md), 32'(MODE_UNPRIV));
    pipe_model_i.issue(3, '0, 32'hf800_0011);
    chk(ss, '0);
    pipe_model_i.issue(2, '0, 32'h4000_00ff);
    chk(cs, 32'h4000_00d0);
    dec(32'hee17_2fb9);
    chk({28'h0, q[22:19]}, 32'h0000_000c);
    bus(1'b1, OFS_MODE, 32'(MODE_SUPERVISOR));
    pipe_model_i.rd(SP_IDX, q);
    chk(q, 32'h0000_a5a0);
    dec(32'hee07_2fb9);
    chk(q, 32'h0053_d92e);
    dec(32'hee17_2fb9);
    chk(q, 32'h004b_d92e);
    dec(32'hee17_2fa9);
    chk({28'h0, q[22:19]}, '0);
    dec(32'hee17_2eb9);
    chk({28'h0, q[22:19]}, '0);
    dec(32'hee37_2fb9);
    chk({28'h0, q[22:19]}, 32'h0000_0008);
    pipe_model_i.issue(0, 5'(PC_IDX), 32'h1234_5677);
    chk(pc, 32'h1234_5674);
    pipe_model_i.rd(PC_IDX, q);
    chk(q, 32'h1234_5674);
    bus(1'b1, OFS_SEL, 32'h0000_0003);
    bus(1'b1, OFS_DATA, 32'h0000_0033);
    pipe_model_i.rd(4'h3, q);
    chk(q, 32'h0000_0033);
    bus(1'b0, 5'h14, '0);
    chk(q, '0);
    pipe_model_i.issue(5, MODE_NORM_IRQ, 32'h0000_0200);
    chk(ss, 32'h4000_00d3);
    bus(1'b0, OFS_STAT, '0);
    chk(q, 32'h4000_00d2);
    bus(1'b0, OFS_SAVED, '0);
    chk(q, 32'h4000_00d3);
    pipe_model_i.rd(LINK_IDX, q);
    chk(q, 32'h0000_0200);
    pipe_model_i.issue(5, MODE_PRIV_TASK, '0);
    chk(32'(md), 32'(MODE_NORM_IRQ));
    bus(1'b1, OFS_MODE, 32'(MODE_SUPERVISOR));
    pipe_model_i.rd(LINK_IDX, q);
    chk(q, 32'h0000_0104);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge clock_i);
      maddr <= ad[i];
      @(posedge clock_i);
      #1;
      chk(32'(rg), 32'(er[i]));
    end
    end_of_test();
  end
endmodule : tb_top
